/* adc_host_pkg.sv */
// constants for the host controller of a half-flash 8-bit converter
// assumes a 40 MHz system clock; all times are in nanoseconds
package adc_host_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // wishbone register offsets (byte addresses)
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] RESULT_OFS = 4'h8;
  localparam logic [3:0] TIMING_OFS = 4'hC;
  // control bit positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_MODE_BIT = 1;
  localparam int unsigned CTRL_SLEEP_BIT = 2;
  localparam int unsigned CTRL_EXTTIME_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status bit positions
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_ASLEEP_BIT = 2;
  localparam int unsigned STAT_WAKING_BIT = 3;
  // timing figures
  localparam int unsigned WAKE_NS = 360;
  localparam int unsigned TRACK_NS = 160;
  localparam int unsigned WR_PULSE_NS = 250;
  localparam int unsigned WR_TO_RD_NS = 250;
  localparam int unsigned ACCESS_NS = 130;
  localparam int unsigned INT_WAIT_NS = 610;
  // least and longest times alike round up to whole clock cycles
  localparam int unsigned WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRACK_CYC = (TRACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_PULSE_CYC = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_TO_RD_CYC = (WR_TO_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INT_WAIT_CYC = (INT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
endpackage

/* adc_pins_if.sv */
// bundle of synchronised converter pin levels passed from the top to the sampler
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface adc_pins_if;
  logic [7:0] bus;
  logic done_n;
  logic ready;
  modport src (output bus, output done_n, output ready);
  modport dst (input bus, input done_n, input ready);
endinterface
`default_nettype wire

/* pin_sync.sv */
// two-stage synchroniser for the converter's output pins
// assumes pins are asynchronous to CLK
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 10
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] pins_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins_in;
      sync_q <= meta_q;
    end
  end
  assign pins_out = sync_q;
endmodule
`default_nettype wire

/* adc_host.sv */
// host controller driving a half-flash 8-bit converter through its bus pins
// assumes a wishbone classic master on the system side and the converter on the pins
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - mode strap low: read-controlled; high: write-then-read; default low
// - strobes count only while select is low; host asserts select each access made while awake
// - host keeps select high throughout sleep
// - host waits 360ns after wake before starting a conversion
// - host keeps select steady in sleep; read and write stay steady and mode follows control writes unless sleep is set in the cycle a start is taken
// - host allows 160ns tracking between conversions in read mode
// - read mode: read strobe fall starts conversion; hold it until data valid
// - external timing: host lowers read 250ns after write rises
// - write mode: host waits 160ns after done falls before next write
// - internal delay: host waits for done, then reads; done clears on rise
module adc_host
  import adc_host_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [3:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic [DATA_W-1:0] RESULT_BUS_IN,
  input wire logic DONE_N_IN,
  input wire logic WR_RDY_IN,
  output logic WR_RDY_OUT,
  output logic WR_RDY_OE_OUT,
  output logic SELECT_N_OUT,
  output logic READ_N_OUT,
  output logic MODE_OUT,
  output logic SLEEP_N_OUT
);
  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_TRACK = 8'b0000_0010,
    ST_RD_WAIT = 8'b0000_0100,
    ST_WR_LOW = 8'b0000_1000,
    ST_WR_GAP = 8'b0001_0000,
    ST_WR_DONE = 8'b0010_0000,
    ST_RD_ACC = 8'b0100_0000,
    ST_RELEASE = 8'b1000_0000
  } state_t;

  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // pins come from the converter's own timing, so they pass two flops first
  adc_pins_if pins ();
  logic [DATA_W+1:0] sync_w;
  pin_sync #(.WIDTH(DATA_W + 2)) u_sync (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(rst_n),
    .pins_in({DONE_N_IN, WR_RDY_IN, RESULT_BUS_IN}),
    .pins_out(sync_w)
  );
  assign pins.bus = sync_w[DATA_W-1:0];
  assign pins.ready = sync_w[DATA_W];
  assign pins.done_n = sync_w[DATA_W+1];

  state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] wake_q;
  logic mode_q, sleep_q, ext_q, start_q;
  logic done_q, timeout_q;
  logic [DATA_W-1:0] result_q;
  logic ack_q;

  // bus decode
  logic wb_req, wb_wr, sel_ctrl, sel_stat, sel_res, sel_tim;
  assign wb_req = WB_CYC_IN && WB_STB_IN && !ack_q;
  assign wb_wr = wb_req && WB_WE_IN && WB_SEL_IN[0];
  assign sel_ctrl = (WB_ADR_IN == CTRL_OFS);
  assign sel_stat = (WB_ADR_IN == STATUS_OFS);
  assign sel_res = (WB_ADR_IN == RESULT_OFS);
  assign sel_tim = (WB_ADR_IN == TIMING_OFS);

  logic busy, asleep, waking, ctrl_wr, start_req, done_set, res_rd;
  assign busy = (state_q != ST_IDLE);
  assign asleep = !sleep_q;
  assign waking = (wake_q != '0);
  assign ctrl_wr = wb_wr && sel_ctrl;
  // start is refused while asleep or waking, holding select high in sleep
  assign start_req = start_q && !busy && !asleep && !waking;
  assign res_rd = wb_req && !WB_WE_IN && sel_res;

  logic [31:0] rd_data;
  // bit 2 reads back as written: one means asleep
  assign rd_data = sel_ctrl ? {28'h000_0000, ext_q, asleep, mode_q, start_q} :
                   sel_stat ? {27'h000_0000, timeout_q, waking, asleep, done_q, busy} :
                   sel_res ? {{(32-DATA_W){1'b0}}, result_q} :
                   sel_tim ? {{(32-CNT_W){1'b0}}, cnt_q} : 32'h0000_0000;

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req;
      WB_DAT_OUT <= wb_req ? rd_data : WB_DAT_OUT;
    end
  end
  assign WB_ACK_OUT = ack_q;

  // control register; start self-clears once taken unless a control write lands that cycle, sleep wake default high
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= CTRL_RESET[CTRL_MODE_BIT];
      sleep_q <= 1'b1;
      ext_q <= CTRL_RESET[CTRL_EXTTIME_BIT];
      start_q <= CTRL_RESET[CTRL_START_BIT];
    end else if (ctrl_wr) begin
      mode_q <= busy ? mode_q : WB_DAT_IN[CTRL_MODE_BIT];
      sleep_q <= busy ? sleep_q : !WB_DAT_IN[CTRL_SLEEP_BIT];
      ext_q <= WB_DAT_IN[CTRL_EXTTIME_BIT];
      start_q <= WB_DAT_IN[CTRL_START_BIT] | start_q;
    end else if (start_req) begin
      start_q <= 1'b0;
    end
  end

  // wake-up hold-off counts down after sleep is released
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= '0;
    end else if (asleep) begin
      wake_q <= CNT_W'(WAKE_CYC);
    end else if (waking) begin
      wake_q <= wake_q - 1'b1;
    end
  end

  // sequencer
  logic cnt_zero;
  assign cnt_zero = (cnt_q == '0);
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_zero ? cnt_q : cnt_q - 1'b1;
    case (state_q)
      ST_IDLE: begin
        if (start_req) begin
          state_d = ST_TRACK;
          cnt_d = CNT_W'(TRACK_CYC);
        end
      end
      ST_TRACK: begin
        if (cnt_zero) begin
          if (mode_q) begin
            state_d = ST_WR_LOW;
            cnt_d = CNT_W'(WR_PULSE_CYC);
          end else begin
            state_d = ST_RD_WAIT;
            cnt_d = CNT_W'(INT_WAIT_CYC);
          end
        end
      end
      ST_RD_WAIT: begin
        // read strobe held low until ready releases and done falls
        if ((pins.ready && !pins.done_n) || cnt_zero) begin
          state_d = ST_RD_ACC;
          cnt_d = CNT_W'(ACCESS_CYC);
        end
      end
      ST_WR_LOW: begin
        if (cnt_zero) begin
          state_d = ext_q ? ST_WR_GAP : ST_WR_DONE;
          cnt_d = ext_q ? CNT_W'(WR_TO_RD_CYC) : CNT_W'(INT_WAIT_CYC);
        end
      end
      ST_WR_GAP: begin
        if (cnt_zero) begin
          state_d = ST_RD_ACC;
          cnt_d = CNT_W'(ACCESS_CYC);
        end
      end
      ST_WR_DONE: begin
        if (!pins.done_n || cnt_zero) begin
          state_d = ST_RD_ACC;
          cnt_d = CNT_W'(ACCESS_CYC);
        end
      end
      ST_RD_ACC: begin
        if (cnt_zero) begin
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  logic timed_out;
  assign timed_out = cnt_zero && pins.done_n &&
                     ((state_q == ST_RD_WAIT) || (state_q == ST_WR_DONE));
  assign done_set = (state_q == ST_RD_ACC) && cnt_zero;

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // both nibbles are present on the bus by now, upper in lines 7..4
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (done_set) begin
      result_q <= pins.bus;
    end
  end

  // set wins over the clear that a result read gives
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      done_q <= done_set | (done_q & !res_rd);
      timeout_q <= timed_out | (timeout_q & !res_rd);
    end
  end

  // pin drive; select only low during an access, never in sleep
  logic access;
  // taken from the next state so select moves on the same edge as the strobes
  assign access = (state_d != ST_IDLE) && (state_d != ST_TRACK) &&
                  (state_d != ST_RELEASE);
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      SELECT_N_OUT <= 1'b1;
      READ_N_OUT <= 1'b1;
      WR_RDY_OUT <= 1'b1;
      WR_RDY_OE_OUT <= 1'b0;
      MODE_OUT <= 1'b0;
      SLEEP_N_OUT <= 1'b1;
    end else begin
      SELECT_N_OUT <= !(access && !asleep);
      READ_N_OUT <= !((state_d == ST_RD_WAIT) || (state_d == ST_RD_ACC));
      WR_RDY_OUT <= !(state_d == ST_WR_LOW);
      // in read mode the pin is the converter's ready output, so never drive it
      WR_RDY_OE_OUT <= mode_q;
      MODE_OUT <= mode_q;
      SLEEP_N_OUT <= sleep_q;
    end
  end
endmodule
`default_nettype wire

/* adc_host_checker.sv */
// concurrent checks on the converter pins and the bus handshake of the host
// assumes it is bound into adc_host and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module adc_host_checker
  import adc_host_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_ACK_OUT,
  input wire logic WR_RDY_OUT,
  input wire logic WR_RDY_OE_OUT,
  input wire logic SELECT_N_OUT,
  input wire logic READ_N_OUT,
  input wire logic MODE_OUT,
  input wire logic SLEEP_N_OUT
);
  logic [7:0] wake_q;
  logic [7:0] trk_q;
  logic wake_top;
  logic trk_top;
  assign wake_top = (wake_q == 8'hFF);
  assign trk_top = (trk_q == 8'hFF);
  // counters start saturated so the first access after reset is not flagged
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wake_q <= 8'hFF;
      trk_q <= 8'hFF;
    end else begin
      wake_q <= !SLEEP_N_OUT ? 8'h00 : wake_q + {7'h00, !wake_top};
      trk_q <= !SELECT_N_OUT ? 8'h00 : trk_q + {7'h00, !trk_top};
    end
  end
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);
  sleep_sel_a: assert property (!SLEEP_N_OUT |-> SELECT_N_OUT)
    else $error("select low while asleep");
  wake_wait_a: assert property ($fell(SELECT_N_OUT) |-> wake_q >= WAKE_CYC)
    else $error("access too soon after wake");
  track_time_a: assert property ($fell(SELECT_N_OUT) |-> trk_q >= TRACK_CYC)
    else $error("tracking time too short");
  strobe_sel_a: assert property ((!READ_N_OUT || (WR_RDY_OE_OUT && !WR_RDY_OUT))
    |-> !SELECT_N_OUT) else $error("strobe without select");
  ready_free_a: assert property (!MODE_OUT |-> !WR_RDY_OE_OUT)
    else $error("ready wire driven in read mode");
  wr_pulse_a: assert property ($fell(WR_RDY_OUT) && WR_RDY_OE_OUT |-> (!WR_RDY_OUT)[*8])
    else $error("write pulse too short");
  wr_to_rd_a: assert property ($rose(WR_RDY_OUT) && MODE_OUT |-> READ_N_OUT[*8])
    else $error("read follows write too soon");
  rd_hold_a: assert property ($fell(READ_N_OUT) |-> (!READ_N_OUT)[*6])
    else $error("read released too early");
  mode_steady_a: assert property (!SELECT_N_OUT |-> $stable(MODE_OUT))
    else $error("mode changed while selected");
  ack_once_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT
    |=> WB_ACK_OUT ##1 !WB_ACK_OUT) else $error("ack not a one cycle answer");
endmodule
`default_nettype wire

/* adc_conv_model.sv */
// behavioural model of the half-flash converter's digital pins
// assumes a board pull-up on the ready wire; the device has no clock
`timescale 1ns/1ps
`default_nettype none
module adc_conv_model #(
  parameter int unsigned CONV_NS = 400,
  parameter int unsigned ACC_NS = 100
) (
  input wire logic select_n_in,
  input wire logic read_n_in,
  input wire logic wr_n_in,
  input wire logic mode_in,
  input wire logic sleep_n_in,
  input wire logic [7:0] sample_in,
  output logic [7:0] result_bus_out,
  output var logic done_n_out,
  output logic ready_low_out
);
  logic [7:0] data_q = 8'h00;
  logic busy_q = 1'b0;
  logic acc_q = 1'b0;
  logic rd_seen = 1'b0;
  initial done_n_out = 1'b1;
  // undriven lines show the inverse so a stale value cannot pass
  assign result_bus_out = (!select_n_in && !read_n_in && acc_q) ? data_q : ~data_q;
  assign ready_low_out = !mode_in && (!sleep_n_in || busy_q);
  always @(negedge select_n_in) if (!mode_in && sleep_n_in) busy_q = 1'b1;
  always @(negedge read_n_in) begin
    acc_q = 1'b0;
    // select and read may fall in the same time step; let both settle
    #1;
    if (!select_n_in && sleep_n_in) begin
      if (!mode_in) begin
        #(CONV_NS);
        data_q = sample_in;
        busy_q = 1'b0;
        done_n_out = 1'b0;
      end else begin
        rd_seen = 1'b1;
        if (done_n_out) data_q[3:0] = sample_in[3:0];
      end
      #(ACC_NS) acc_q = 1'b1;
    end
  end
  always @(posedge wr_n_in) begin
    if (mode_in && !select_n_in && sleep_n_in) begin
      data_q[7:4] = sample_in[7:4];
      rd_seen = 1'b0;
      #380;
      if (!rd_seen) begin
        data_q[3:0] = sample_in[3:0];
        done_n_out = 1'b0;
      end
    end
  end
  always @(posedge select_n_in or posedge read_n_in) begin
    done_n_out = 1'b1;
    acc_q = 1'b0;
  end
endmodule
`default_nettype wire

/* adc_host_tb_top.sv */
// bench: wishbone master tasks drive the host, the converter model answers on the pins
// assumes adc_host, its checker and the converter model are compiled first
`timescale 1ns/1ps
`default_nettype none
module adc_host_tb_top
  import adc_host_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h1;
  logic [31:0] dat_w = 32'h0000_0000;
  logic [31:0] dat_r;
  logic ack;
  logic [7:0] bus;
  logic [7:0] sample = 8'h00;
  logic done_n, wr_out, wr_oe, sel_n, rd_n, mode, sleep_n, ready_low, wr_wire;
  logic [31:0] q;
  int err_count = 0;
  int comparisons = 0;
  // the released ready wire is held high by a board pull-up
  assign wr_wire = wr_oe ? wr_out : !ready_low;
  initial forever #12.5 clk = ~clk;
  adc_host adc_host_inst (.CLK_SYS_IN(clk), .ARST_N_IN(arst_n), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat_w),
    .WB_DAT_OUT(dat_r), .WB_ACK_OUT(ack), .RESULT_BUS_IN(bus), .DONE_N_IN(done_n),
    .WR_RDY_IN(wr_wire), .WR_RDY_OUT(wr_out), .WR_RDY_OE_OUT(wr_oe), .SELECT_N_OUT(sel_n),
    .READ_N_OUT(rd_n), .MODE_OUT(mode), .SLEEP_N_OUT(sleep_n));
  adc_conv_model adc_conv_model_inst (.select_n_in(sel_n), .read_n_in(rd_n),
    .wr_n_in(wr_wire), .mode_in(mode), .sleep_n_in(sleep_n), .sample_in(sample),
    .result_bus_out(bus), .done_n_out(done_n), .ready_low_out(ready_low));
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      chk("bus answer", 32'h0000_0000, 32'h0000_0001);
      end_of_test();
    end
  endtask
  task automatic conv(input logic [31:0] ctrl, input logic [7:0] smp);
    int n;
    sample = smp;
    wb(1'b1, CTRL_OFS, ctrl);
    n = 0;
    do begin
      wb(1'b0, STATUS_OFS, 32'h0000_0000);
      n++;
    end while (q[STAT_DONE_BIT] !== 1'b1 && n < 50);
    chk("done", {31'h0000_0000, q[STAT_DONE_BIT]}, 32'h0000_0001);
    if (q[STAT_DONE_BIT] !== 1'b1) end_of_test();
    wb(1'b0, RESULT_OFS, 32'h0000_0000);
    chk("result", q, {24'h00_0000, smp});
    wb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("done cleared", {31'h0000_0000, q[STAT_DONE_BIT]}, 32'h0000_0000);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("idle pins", {26'h000_0000, sel_n, rd_n, wr_out, wr_oe, mode, sleep_n},
      32'h0000_0039);
    wb(1'b0, CTRL_OFS, 32'h0000_0000);
    chk("ctrl reset", q, CTRL_RESET);
    wb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("status reset", q, 32'h0000_0000);
    wb(1'b1, 4'h2, 32'h0000_000F);
    wb(1'b0, 4'h2, 32'h0000_0000);
    chk("unmapped", q, 32'h0000_0000);
    conv(32'h0000_0001, 8'hA5);
    conv(32'h0000_0001, 8'h5A);
    conv(32'h0000_0003, 8'h3C);
    conv(32'h0000_0003, 8'hC3);
    conv(32'h0000_000B, 8'h81);
    conv(32'h0000_0001, 8'h7E);
    wb(1'b1, CTRL_OFS, 32'h0000_0004);
    repeat (4) @(posedge clk);
    chk("sleep pin", {31'h0000_0000, sleep_n}, 32'h0000_0000);
    chk("ready asleep", {31'h0000_0000, wr_wire}, 32'h0000_0000);
    wb(1'b1, CTRL_OFS, 32'h0000_0005);
    repeat (40) @(posedge clk);
    wb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("asleep", q & 32'h0000_0007, 32'h0000_0004);
    chk("select idle", {31'h0000_0000, sel_n}, 32'h0000_0001);
    conv(32'h0000_0001, 8'h42);
    end_of_test();
  end
endmodule
bind adc_host adc_host_checker adc_host_checker_inst (.CLK_SYS_IN(CLK_SYS_IN),
  .ARST_N_IN(ARST_N_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
  .WB_ACK_OUT(WB_ACK_OUT), .WR_RDY_OUT(WR_RDY_OUT), .WR_RDY_OE_OUT(WR_RDY_OE_OUT),
  .SELECT_N_OUT(SELECT_N_OUT), .READ_N_OUT(READ_N_OUT), .MODE_OUT(MODE_OUT),
  .SLEEP_N_OUT(SLEEP_N_OUT));
`default_nettype wire
